//--- brc_defs.svh
// Field positions, reset values and codes of the burst configuration register
`ifndef BRC_DEFS_SVH
`define BRC_DEFS_SVH

`define BRC_CFG_W          16
`define BRC_CFG_DEFAULT    16'hdf48
`define BRC_BIT_READ_MODE  15
`define BRC_WAIT_MSB       14
`define BRC_WAIT_LSB       11
`define BRC_BIT_RDY_POL    10
`define BRC_BIT_RDY_TIMING 8
`define BRC_BIT_HALF_DRIVE 7
`define BRC_BLEN_MSB       2
`define BRC_BLEN_LSB       0

`define BRC_WAIT_MIN_CODE  4'h1
`define BRC_WAIT_MAX_CODE  4'hb
`define BRC_WAIT_OFFSET    4'h2

`define BRC_BLEN_CONT      3'h0
`define BRC_BLEN_WRAP8     3'h2
`define BRC_BLEN_WRAP16    3'h3
`define BRC_WRAP8_LAST     4'h7
`define BRC_WRAP16_LAST    4'hf

`endif

//--- brc_pkg.sv
// Types shared by the burst configuration block
package brc_pkg;
	typedef enum logic [1:0] {BRC_IDLE, BRC_WAIT, BRC_DATA} brc_state_t;
	typedef logic [2:0] brc_blen_t;
endpackage

//--- brc_addr_gen.sv
// Burst word address counter: continuous, 8-word and 16-word wrap
`timescale 1ns/100ps
`include "brc_defs.svh"
module brc_addr_gen
	import brc_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              load_i,
	input  wire logic [ADDR_W-1:0] start_addr_i,
	input  wire logic              advance_i,
	input  wire brc_blen_t         blen_i,
	output logic      [ADDR_W-1:0] addr_o
);
	logic [3:0] word_cnt;
	logic       at_last;

	generate
		if (ADDR_W < 4) begin : g_chk
			$error("ADDR_W must be at least 4");
		end
	endgenerate

	// Wrap bursts stop advancing on the last word and keep driving it
	always_comb begin
		case (blen_i)
			`BRC_BLEN_WRAP8:  at_last = (word_cnt == `BRC_WRAP8_LAST);
			`BRC_BLEN_WRAP16: at_last = (word_cnt == `BRC_WRAP16_LAST);
			default:          at_last = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_o   <= '0;
			word_cnt <= 4'h0;
		end else if (load_i) begin
			addr_o   <= start_addr_i;
			word_cnt <= 4'h0;
		end else if (advance_i && !at_last) begin
			word_cnt <= word_cnt + 4'h1;
			case (blen_i)
				`BRC_BLEN_WRAP8: begin
					addr_o[2:0] <= addr_o[2:0] + 3'h1;
				end
				`BRC_BLEN_WRAP16: begin
					addr_o[3:0] <= addr_o[3:0] + 4'h1;
				end
				default: begin
					addr_o <= addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
				end
			endcase
		end
	end
endmodule // brc_addr_gen

//--- brc_burst_config.sv
// Burst configuration register with the synchronous burst read sequencer it steers
// Operation
// - Power-up or hardware reset sends the block idle and loads every field default.
// - A configuration read returns the current register contents.
// - A command reset leaves the register untouched.
// - Bit 15 picks synchronous burst when zero and asynchronous reads when one, default one.
// - Writes always use asynchronous timing, so a write cycle never starts a burst.
// - Wait code 0001 puts first data on the 3rd edge, each step one more, 1011 the 13th.
// - Latency counts from the address strobe cycle that captures the start address.
// - After the wait the first word is driven, then one word per edge with address advance.
// - Bit 10 sets the valid indicator active high when one and active low when zero.
// - Bit 8 zero raises the indicator one clock before data, one raises it with data.
// - Bit 7 picks full drive when zero and half drive when one, default zero.
// - Burst length 000 is continuous, 010 an 8-word wrap, 011 a 16-word wrap.
// - Reserved bits 9, 6, 3 reset to one and bits 5, 4 to zero.
// - Continuous bursts run on and wrap past the top until deselect, reset or a new address.
// - Wrap bursts stay in their aligned group and then hold the last word.
`timescale 1ns/100ps
`include "brc_defs.svh"
module brc_burst_config
	import brc_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	input  wire logic              CMD_RESET_I,
	input  wire logic              CFG_WR_I,
	input  wire logic [15:0]       CFG_WDATA_I,
	input  wire logic              CFG_RD_I,
	input  wire logic              CE_N_I,
	input  wire logic              WE_N_I,
	input  wire logic              ADDRESS_VALID_STROBE_N_I,
	input  wire logic [ADDR_W-1:0] ADDR_I,
	output logic      [15:0]       CFG_RDATA_O,
	output logic                   CFG_RVALID_O,
	output logic                   SYNC_MODE_O,
	output logic                   HALF_DRIVE_O,
	output logic                   DATA_OUT_EN_O,
	output logic                   DATA_VALID_O,
	output logic      [ADDR_W-1:0] RD_ADDR_O
);
	logic [15:0] burst_config_reg;
	brc_state_t  state;
	brc_state_t  next_state;
	logic [3:0]  wait_cnt;
	logic [3:0]  next_wait_cnt;
	logic        start;
	logic        b_pol;
	logic        b_early;
	brc_blen_t   b_blen;
	logic        next_ind;
	logic [3:0]  lat_cnt;
	logic [3:0]  lat_w;

	// Reserved wait codes fall back to the slowest legal setting
	function automatic logic [3:0] latency(input logic [3:0] code);
		if (code < `BRC_WAIT_MIN_CODE || code > `BRC_WAIT_MAX_CODE)
			return `BRC_WAIT_MAX_CODE + `BRC_WAIT_OFFSET;
		return code + `BRC_WAIT_OFFSET;
	endfunction

	// Reserved length codes run as continuous
	function automatic brc_blen_t blen_decode(input logic [2:0] code);
		if (code == `BRC_BLEN_WRAP8 || code == `BRC_BLEN_WRAP16)
			return code;
		return `BRC_BLEN_CONT;
	endfunction

	// Whole-word update; a command reset has no path into it
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			burst_config_reg <= `BRC_CFG_DEFAULT;
		end else if (CFG_WR_I) begin
			burst_config_reg <= CFG_WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CFG_RDATA_O  <= 16'h0000;
			CFG_RVALID_O <= 1'b0;
		end else begin
			CFG_RVALID_O <= CFG_RD_I;
			if (CFG_RD_I) begin
				CFG_RDATA_O <= burst_config_reg;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SYNC_MODE_O  <= 1'b0;
			HALF_DRIVE_O <= 1'b0;
		end else begin
			SYNC_MODE_O  <= !burst_config_reg[`BRC_BIT_READ_MODE];
			HALF_DRIVE_O <= burst_config_reg[`BRC_BIT_HALF_DRIVE];
		end
	end

	// Only a synchronous read cycle latches a burst start address
	assign start = !burst_config_reg[`BRC_BIT_READ_MODE] && !CE_N_I && WE_N_I
		&& !ADDRESS_VALID_STROBE_N_I;

	always_comb begin
		next_state    = state;
		next_wait_cnt = wait_cnt;
		if (CMD_RESET_I || CE_N_I) begin
			next_state = BRC_IDLE;
		end else if (start) begin
			next_state    = BRC_WAIT;
			next_wait_cnt = latency(burst_config_reg[`BRC_WAIT_MSB:`BRC_WAIT_LSB]);
		end else begin
			case (state)
				BRC_WAIT: begin
					next_wait_cnt = wait_cnt - 4'h1;
					if (wait_cnt == 4'h1)
						next_state = BRC_DATA;
				end
				BRC_DATA: next_state = BRC_DATA;
				default:  next_state = BRC_IDLE;
			endcase
		end
		next_ind = (next_state == BRC_DATA)
			|| (b_early && next_state == BRC_WAIT && next_wait_cnt == 4'h1 && !start);
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state    <= BRC_IDLE;
			wait_cnt <= 4'h0;
		end else begin
			state    <= next_state;
			wait_cnt <= next_wait_cnt;
		end
	end

	// Snapshot at burst start so a later write cannot disturb a running burst
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			b_pol   <= 1'b1;
			b_early <= 1'b0;
			b_blen  <= `BRC_BLEN_CONT;
		end else if (start) begin
			b_pol   <= burst_config_reg[`BRC_BIT_RDY_POL];
			b_early <= !burst_config_reg[`BRC_BIT_RDY_TIMING];
			b_blen  <= blen_decode(burst_config_reg[`BRC_BLEN_MSB:`BRC_BLEN_LSB]);
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DATA_OUT_EN_O <= 1'b0;
			DATA_VALID_O  <= 1'b0;
		end else begin
			DATA_OUT_EN_O <= (next_state == BRC_DATA);
			DATA_VALID_O  <= start ? !burst_config_reg[`BRC_BIT_RDY_POL]
				: (b_pol ? next_ind : !next_ind);
		end
	end

	brc_addr_gen #(
		.ADDR_W(ADDR_W)
	) u_addr (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.load_i      (start),
		.start_addr_i(ADDR_I),
		.advance_i   (state == BRC_DATA && next_state == BRC_DATA),
		.blen_i      (b_blen),
		.addr_o      (RD_ADDR_O)
	);

	// Assertion helpers: cycles since the address strobe and the expected latency
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lat_cnt <= 4'h0;
			lat_w   <= 4'h0;
		end else if (start) begin
			lat_cnt <= 4'h0;
			lat_w   <= latency(burst_config_reg[`BRC_WAIT_MSB:`BRC_WAIT_LSB]);
		end else if (lat_cnt != 4'hf) begin
			lat_cnt <= lat_cnt + 4'h1;
		end
	end

	sequence s_start;
		start && !CMD_RESET_I;
	endsequence
	sequence s_first_word;
		$rose(DATA_OUT_EN_O);
	endsequence

	property p_reset_default;
		@(posedge CLK_I) $rose(RST_N_I) |-> burst_config_reg == `BRC_CFG_DEFAULT && state == BRC_IDLE;
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("reset defaults wrong");

	property p_cfg_read;
		@(posedge CLK_I) disable iff (!RST_N_I)
		CFG_RD_I |=> CFG_RVALID_O && CFG_RDATA_O == $past(burst_config_reg);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read mismatch");

	property p_cmd_reset_keeps;
		@(posedge CLK_I) disable iff (!RST_N_I)
		CMD_RESET_I && !CFG_WR_I |=> $stable(burst_config_reg) && state == BRC_IDLE;
	endproperty
	a_cmd_reset_keeps: assert property (p_cmd_reset_keeps) else $error("command reset touched cfg");

	property p_cfg_write;
		@(posedge CLK_I) disable iff (!RST_N_I)
		CFG_WR_I |=> burst_config_reg == $past(CFG_WDATA_I);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not whole");

	property p_mode_pins;
		@(posedge CLK_I) disable iff (!RST_N_I)
		1'b1 |=> SYNC_MODE_O == !$past(burst_config_reg[15]) && HALF_DRIVE_O == $past(burst_config_reg[7]);
	endproperty
	a_mode_pins: assert property (p_mode_pins) else $error("mode outputs wrong");

	property p_no_write_burst;
		@(posedge CLK_I) disable iff (!RST_N_I)
		!WE_N_I || burst_config_reg[15] |-> !start;
	endproperty
	a_no_write_burst: assert property (p_no_write_burst) else $error("burst began on write");

	property p_latency;
		@(posedge CLK_I) disable iff (!RST_N_I)
		s_first_word |-> lat_cnt == lat_w && lat_w >= 4'h3 && lat_w <= 4'hd;
	endproperty
	a_latency: assert property (p_latency) else $error("first data at wrong edge");

	property p_first_addr;
		@(posedge CLK_I) disable iff (!RST_N_I)
		s_start ##1 (!start && !CE_N_I && !CMD_RESET_I)[*4] ##0 s_first_word
			|-> RD_ADDR_O == $past(ADDR_I, 4);
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("first word address wrong");

	property p_cont_advance;
		@(posedge CLK_I) disable iff (!RST_N_I)
		DATA_OUT_EN_O && $past(DATA_OUT_EN_O) && b_blen == `BRC_BLEN_CONT && !$past(start)
			|-> RD_ADDR_O == $past(RD_ADDR_O) + 1'b1;
	endproperty
	a_cont_advance: assert property (p_cont_advance) else $error("address did not advance");

	property p_ind_level;
		@(posedge CLK_I) disable iff (!RST_N_I)
		DATA_OUT_EN_O |-> DATA_VALID_O == b_pol;
	endproperty
	a_ind_level: assert property (p_ind_level) else $error("indicator level wrong");

	property p_ind_early;
		@(posedge CLK_I) disable iff (!RST_N_I)
		b_early && !DATA_OUT_EN_O && DATA_VALID_O == b_pol && !CE_N_I && !start && !CMD_RESET_I
			|=> DATA_OUT_EN_O;
	endproperty
	a_ind_early: assert property (p_ind_early) else $error("early indicator misplaced");

	property p_wrap_group;
		@(posedge CLK_I) disable iff (!RST_N_I)
		DATA_OUT_EN_O && $past(DATA_OUT_EN_O) && b_blen == `BRC_BLEN_WRAP8 && !$past(start)
			|-> RD_ADDR_O[ADDR_W-1:3] == $past(RD_ADDR_O[ADDR_W-1:3]);
	endproperty
	a_wrap_group: assert property (p_wrap_group) else $error("wrap left its group");

	property p_deselect;
		@(posedge CLK_I) disable iff (!RST_N_I)
		CE_N_I |=> !DATA_OUT_EN_O;
	endproperty
	a_deselect: assert property (p_deselect) else $error("data driven after deselect");
endmodule // brc_burst_config

//--- brc_host_model.sv
// Host controller model driving the configuration and burst pins
`timescale 1ns/100ps
module brc_host_model #(
	parameter int ADDR_W = 24
) (
	input  wire logic              clk_i,
	output logic                   cmd_reset_o,
	output logic                   cfg_wr_o,
	output logic      [15:0]       cfg_wdata_o,
	output logic                   cfg_rd_o,
	output logic                   ce_n_o,
	output logic                   we_n_o,
	output logic                   strobe_n_o,
	output logic      [ADDR_W-1:0] addr_o
);
	initial begin
		cmd_reset_o = 1'b0;
		cfg_wr_o    = 1'b0;
		cfg_wdata_o = 16'h0000;
		cfg_rd_o    = 1'b0;
		ce_n_o      = 1'b1;
		we_n_o      = 1'b1;
		strobe_n_o  = 1'b1;
		addr_o      = '0;
	end
	// Kind 0 write, 1 read, 2 command reset; data inverted afterwards so stale words never match
	task automatic pulse(input int kind, input logic [15:0] d);
		@(negedge clk_i);
		cfg_wr_o    = (kind == 0);
		cfg_rd_o    = (kind == 1);
		cmd_reset_o = (kind == 2);
		cfg_wdata_o = d;
		@(negedge clk_i);
		cfg_wr_o    = 1'b0;
		cfg_rd_o    = 1'b0;
		cmd_reset_o = 1'b0;
		cfg_wdata_o = ~d;
	endtask
	// Strobe low for one rising edge only, then the address bus turns over
	task automatic start(input logic [ADDR_W-1:0] a, input logic we_n);
		@(negedge clk_i);
		ce_n_o     = 1'b0;
		we_n_o     = we_n;
		strobe_n_o = 1'b0;
		addr_o     = a;
		@(negedge clk_i);
		we_n_o     = 1'b1;
		strobe_n_o = 1'b1;
		addr_o     = ~a;
	endtask
	task automatic deselect();
		ce_n_o = 1'b1;
	endtask
endmodule // brc_host_model

//--- burst_read_config_register_test.sv
// Self-checking bench of the burst configuration register and burst sequencer
`timescale 1ns/100ps
`include "brc_defs.svh"
`define BRC_CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module burst_read_config_register_test;
	logic        clk, rst_n, cmd_reset, cfg_wr, cfg_rd, ce_n, we_n, strobe_n;
	logic [15:0] cfg_wdata, cfg_rdata, exp16;
	logic [23:0] addr, rd_addr, exp24;
	logic        cfg_rvalid, sync_mode, half_drive, data_out_en, data_valid;
	int          errors, cmp_count;
	integer      seed;
	logic [15:0] exp_rd_q[$];
	logic [23:0] exp_addr_q[$];

	brc_host_model #(.ADDR_W(24)) host (.clk_i(clk), .cmd_reset_o(cmd_reset), .cfg_wr_o(cfg_wr),
		.cfg_wdata_o(cfg_wdata), .cfg_rd_o(cfg_rd), .ce_n_o(ce_n), .we_n_o(we_n),
		.strobe_n_o(strobe_n), .addr_o(addr));
	brc_burst_config #(.ADDR_W(24)) dut (.CLK_I(clk), .RST_N_I(rst_n), .CMD_RESET_I(cmd_reset),
		.CFG_WR_I(cfg_wr), .CFG_WDATA_I(cfg_wdata), .CFG_RD_I(cfg_rd), .CE_N_I(ce_n),
		.WE_N_I(we_n), .ADDRESS_VALID_STROBE_N_I(strobe_n), .ADDR_I(addr),
		.CFG_RDATA_O(cfg_rdata), .CFG_RVALID_O(cfg_rvalid), .SYNC_MODE_O(sync_mode),
		.HALF_DRIVE_O(half_drive), .DATA_OUT_EN_O(data_out_en), .DATA_VALID_O(data_valid),
		.RD_ADDR_O(rd_addr));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Results arrive one at a time; anything unannounced counts as a mismatch
	always @(negedge clk) begin
		if (cfg_rvalid === 1'b1 && exp_rd_q.size() > 0) begin
			exp16 = exp_rd_q.pop_front();
			`BRC_CHK(cfg_rdata, exp16)
		end else if (cfg_rvalid === 1'b1) begin
			`BRC_CHK(cfg_rvalid, 1'b0)
		end
		if (data_out_en === 1'b1 && exp_addr_q.size() > 0) begin
			exp24 = exp_addr_q.pop_front();
			`BRC_CHK(rd_addr, exp24)
		end else if (data_out_en === 1'b1) begin
			`BRC_CHK(data_out_en, 1'b0)
		end
	end

	function automatic logic [23:0] word_addr(input logic [23:0] a, input logic [2:0] bl, input int i);
		int j;
		j = (i > 15) ? 15 : i;
		case (bl)
			`BRC_BLEN_WRAP8: word_addr = {a[23:3], 3'(a[2:0] + 3'((j > 7) ? 7 : j))};
			`BRC_BLEN_WRAP16: word_addr = {a[23:4], 4'(a[3:0] + 4'(j))};
			default: word_addr = a + 24'(i);
		endcase
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic no_burst(input logic we_low);
		host.start(24'($random(seed)), ~we_low);
		repeat (15) @(negedge clk);
		`BRC_CHK(data_out_en, 1'b0)
		host.deselect();
		$display("no burst test done");
	endtask

	task automatic burst(input logic [3:0] code, input logic [2:0] bl, input logic [23:0] a, input int n);
		logic [15:0] cfg;
		logic        pol;
		logic        late;
		int          k;
		pol = 1'($random(seed));
		late = 1'($random(seed));
		cfg = {1'b0, code, pol, 1'b1, late, 1'($random(seed)), 4'h9, bl};
		host.pulse(0, cfg);
		exp_rd_q.push_back(cfg);
		host.pulse(1, 16'h0000);
		`BRC_CHK(sync_mode, 1'b1)
		`BRC_CHK(half_drive, cfg[7])
		for (k = 0; k < n; k++) exp_addr_q.push_back(word_addr(a, bl, k));
		host.start(a, 1'b1);
		k = 0;
		while (data_out_en !== 1'b1 && k < 15) begin
			@(negedge clk);
			k++;
			if (k == code + 1) `BRC_CHK(data_valid, late ? ~pol : pol)
		end
		`BRC_CHK(k, code + 2)
		if (k >= 15) give_verdict();
		`BRC_CHK(data_valid, pol)
		repeat (n - 1) @(negedge clk);
		host.deselect();
		@(negedge clk);
		`BRC_CHK(data_valid, ~pol)
		$display("burst test code %0d done", code);
	endtask

	initial begin
		logic [15:0] v;
		seed = 32'h8086fe73;
		errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		exp_rd_q.push_back(`BRC_CFG_DEFAULT);
		host.pulse(1, 16'h0000);
		`BRC_CHK(sync_mode, 1'b0)
		`BRC_CHK(half_drive, 1'b0)
		`BRC_CHK(data_valid, 1'b0)
		no_burst(1'b0);
		v = 16'($random(seed)) | 16'h8000;
		host.pulse(0, v);
		host.pulse(2, 16'h0000);
		exp_rd_q.push_back(v);
		host.pulse(1, 16'h0000);
		$display("command reset test done");
		for (int c = 1; c <= 11; c++) begin
			case (c % 3)
				0: burst(4'(c), `BRC_BLEN_CONT, (c == 9) ? 24'hfffffe : 24'($random(seed)), 5);
				1: burst(4'(c), `BRC_BLEN_WRAP8, 24'($random(seed)), 10);
				default: burst(4'(c), `BRC_BLEN_WRAP16, 24'($random(seed)), 18);
			endcase
		end
		// Reserved length code must run as a continuous burst
		burst(4'h1, 3'h5, 24'($random(seed)), 5);
		// New strobe in mid-burst restarts at the new address
		exp_addr_q.push_back(24'h000123);
		for (int i = 0; i < 3; i++) exp_addr_q.push_back(24'h000456 + 24'(i));
		host.start(24'h000123, 1'b1);
		repeat (2) @(negedge clk);
		host.start(24'h000456, 1'b1);
		repeat (5) @(negedge clk);
		host.deselect();
		@(negedge clk);
		`BRC_CHK(data_out_en, 1'b0)
		$display("restart test done");
		// Command reset ends a running burst but keeps the register
		host.pulse(0, 16'h0f48);
		exp_addr_q.push_back(24'h000789);
		host.start(24'h000789, 1'b1);
		repeat (2) @(negedge clk);
		host.pulse(2, 16'h0000);
		`BRC_CHK(data_out_en, 1'b0)
		host.deselect();
		exp_rd_q.push_back(16'h0f48);
		host.pulse(1, 16'h0000);
		$display("abort test done");
		no_burst(1'b1);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		exp_rd_q.push_back(`BRC_CFG_DEFAULT);
		host.pulse(1, 16'h0000);
		@(negedge clk);
		`BRC_CHK(exp_rd_q.size() + exp_addr_q.size(), 0)
		$display("hardware reset test done");
		give_verdict();
	end
endmodule // burst_read_config_register_test
